// *** bench/led_group_pattern_regs_tb_top.sv ***
// bench for the group / pattern register bank
// assumes the host model owns the byte port and the run bit
`timescale 1ns/1ns
module led_group_pattern_regs_tb_top
  import led_group_pkg::*;
();
  // clock, reset and design-facing signals
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fade_max, fade_min;
  logic reg_write, reg_read, reg_hit, pattern_on, run, off_start, rise_start, running, loop_over;
  logic [143:0] scale_in, scale_out;
  logic [11:0] duty, repeat_count;
  logic [1:0] stop_point;
  logic [17:0] group_mode, pattern_mode;
  logic [7:0] own_base;
  int bad_count = 0;
  int checked = 0;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  // block under test and its host
  led_group_pattern_regs #(.CHANNEL_COUNT(18)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write), .reg_read_in(reg_read),
    .reg_rdata_out(reg_rdata), .reg_hit_out(reg_hit), .pattern_engine_on_in(pattern_on), .run_in(run),
    .off_phase_start_in(off_start), .rise_phase_start_in(rise_start), .channel_colour_scaling_in(scale_in),
    .group_duty_out(duty), .fade_max_out(fade_max), .fade_min_out(fade_min),
    .loop_repeat_count_out(repeat_count), .loop_stop_point_out(stop_point),
    .channel_group_mode_out(group_mode), .channel_pattern_mode_out(pattern_mode),
    .channel_scale_out(scale_out), .loop_running_out(running), .loop_over_out(loop_over));
  reg_host_model host (.clk_in(clk_in), .reg_rdata_in(reg_rdata), .reg_hit_in(reg_hit),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_write_out(reg_write),
    .reg_read_out(reg_read), .run_out(run));

  // trio bit k covers channels 3k..3k+2 (counted from 0)
  function automatic logic [17:0] trio_mask(input logic [7:0] cfg);
    for (int n = 0; n < 18; n++) trio_mask[n] = cfg[n/3];
  endfunction : trio_mask

  // shared bytes 11/22/33 only where the trio is on and sharing is allowed
  function automatic logic [143:0] exp_scale(input logic [7:0] cfg);
    logic [7:0] shared [3];
    shared = '{8'h11, 8'h22, 8'h33};
    for (int n = 0; n < 18; n++) exp_scale[8*n +: 8] = (cfg[n/3] && !cfg[6]) ? shared[n%3] : own_base + n[7:0];
  endfunction : exp_scale

  // per-channel own bytes from a base, changed at a falling edge
  task automatic load_own(input logic [7:0] base);
    @(negedge clk_in);
    own_base = base;
    for (int n = 0; n < 18; n++) scale_in[8*n +: 8] = base + n[7:0];
  endtask : load_own

  // the one comparison, wide enough for every result
  task automatic cmp_vec(input logic [143:0] got, input logic [143:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_vec

  // read through the host and judge data and hit together
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input logic exp_hit);
    logic [7:0] data;
    logic hit;
    host.read_byte(addr, data, hit);
    cmp_vec(144'(data), 144'(exp));
    cmp_vec(144'(hit), 144'(exp_hit));
  endtask : rd_chk

  // mode bit is a plain level; outputs are combinational so allow 1 ns
  task automatic set_mode(input logic on);
    @(negedge clk_in);
    pattern_on = on;
    #1;
  endtask : set_mode

  // one-cycle phase pulse, then room for the registered status
  task automatic pulse(input logic rise);
    @(negedge clk_in);
    rise_start = rise;
    off_start = ~rise;
    @(negedge clk_in);
    rise_start = 1'b0;
    off_start = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask : pulse

  task automatic chk_loop(input logic exp_run, input logic exp_over);
    cmp_vec(144'(running), 144'(exp_run));
    cmp_vec(144'(loop_over), 144'(exp_over));
  endtask : chk_loop

  // every register reads zero after reset; an unmapped place misses
  task automatic test_reset();
    for (int a = 8'h84; a <= 8'h8B; a++) rd_chk(a[7:0], REG_RESET, 1'b1);
    host.write_byte(8'h90, 8'hFF);
    rd_chk(8'h90, UNMAPPED_READ, 1'b0);
    rd_chk(LOOP_REPEAT_LOW_OFS, 8'h00, 1'b1);
    $display("test reset done");
  endtask : test_reset

  // count joins high nibble and low byte with no shadowing
  task automatic test_count();
    host.write_byte(LOOP_TIME_OFS, 8'hC5);
    host.write_byte(LOOP_REPEAT_LOW_OFS, 8'h3A);
    cmp_vec(144'(repeat_count), 144'(12'h53A));
    cmp_vec(144'(stop_point), 144'(2'h3));
    rd_chk(LOOP_REPEAT_LOW_OFS, 8'h3A, 1'b1);
    rd_chk(LOOP_TIME_OFS, 8'hC5, 1'b1);
    $display("test count done");
  endtask : test_count

  // same two bytes read as brightness or as fade limits
  task automatic test_level();
    set_mode(1'b0);
    host.write_byte(GROUP_LEVEL_HIGH_OFS, 8'hAB);
    host.write_byte(GROUP_LEVEL_LOW_OFS, 8'hCD);
    cmp_vec(144'(duty), 144'(12'hBCD));
    set_mode(1'b1);
    cmp_vec(144'(fade_max), 144'(8'hAB));
    cmp_vec(144'(fade_min), 144'(8'hCD));
    cmp_vec(144'(duty), 144'(12'h000));
    set_mode(1'b0);
    cmp_vec(144'({fade_max, fade_min}), 144'(16'h0000));
    $display("test level done");
  endtask : test_level

  // shared colour bytes against own bytes over several trio patterns
  task automatic test_scale();
    logic [7:0] cfgs [4];
    cfgs = '{8'h05, 8'h3A, 8'h7F, 8'h80};
    host.write_byte(GROUP_RED_OFS, 8'h11);
    host.write_byte(GROUP_GREEN_OFS, 8'h22);
    host.write_byte(GROUP_BLUE_OFS, 8'h33);
    foreach (cfgs[i]) begin
      load_own(own_base + 8'h10);
      host.write_byte(GROUP_CONFIG_OFS, cfgs[i]);
      cmp_vec(scale_out, exp_scale(cfgs[i]));
      cmp_vec(144'(group_mode), 144'(trio_mask(cfgs[i])));
      cmp_vec(144'(pattern_mode), 144'(0));
      set_mode(1'b1);
      cmp_vec(144'(pattern_mode), 144'(trio_mask(cfgs[i])));
      cmp_vec(scale_out, exp_scale(cfgs[i]));
      set_mode(1'b0);
    end
    rd_chk(GROUP_CONFIG_OFS, 8'h80, 1'b1);
    $display("test scale done");
  endtask : test_scale

  // finite loops end on the chosen boundary; zero count never ends
  task automatic test_loop();
    host.write_byte(LOOP_TIME_OFS, 8'h00);
    host.write_byte(LOOP_REPEAT_LOW_OFS, 8'h02);
    host.set_run(1'b1);
    @(negedge clk_in);
    chk_loop(1'b1, 1'b0);
    pulse(1'b1);
    pulse(1'b0);
    chk_loop(1'b1, 1'b0);
    pulse(1'b0);
    chk_loop(1'b0, 1'b1);
    host.set_run(1'b0);
    host.write_byte(LOOP_TIME_OFS, 8'h40);
    host.write_byte(LOOP_REPEAT_LOW_OFS, 8'h01);
    host.set_run(1'b1);
    @(negedge clk_in);
    chk_loop(1'b1, 1'b0);
    pulse(1'b0);
    chk_loop(1'b1, 1'b0);
    pulse(1'b1);
    chk_loop(1'b0, 1'b1);
    host.set_run(1'b0);
    host.write_byte(LOOP_TIME_OFS, 8'h00);
    host.write_byte(LOOP_REPEAT_LOW_OFS, 8'h00);
    host.set_run(1'b1);
    repeat (3) pulse(1'b0);
    chk_loop(1'b1, 1'b0);
    host.set_run(1'b0);
    repeat (2) @(negedge clk_in);
    chk_loop(1'b0, 1'b0);
    $display("test loop done");
  endtask : test_loop

  // single exit of the run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  // main sequence: 2 cycles of reset, then the tests
  initial begin
    pattern_on = 1'b0;
    off_start = 1'b0;
    rise_start = 1'b0;
    own_base = 8'h80;
    for (int n = 0; n < 18; n++) scale_in[8*n +: 8] = 8'h80 + n[7:0];
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    test_reset();
    test_count();
    test_level();
    test_scale();
    test_loop();
    wrap_up();
  end

  // watchdog: the tests need well under 20000 cycles
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule : led_group_pattern_regs_tb_top

// *** bench/reg_host_model.sv ***
// host side model: byte register accesses and the pattern run bit
// assumes the bench calls its tasks; every change lands on a falling edge
`timescale 1ns/1ns
module reg_host_model (
  // clock
  input wire logic clk_in,
  // answer from the register bank
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_hit_in,
  // requests to the register bank
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_write_out,
  output logic reg_read_out,
  output logic run_out
);
  // quiet bus at time zero
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    run_out = 1'b0;
  end

  // one byte write; released lines show the inverse so stale data never passes
  task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    reg_addr_out = addr;
    reg_wdata_out = data;
    reg_write_out = 1'b1;
    @(negedge clk_in);
    reg_write_out = 1'b0;
    reg_addr_out = ~addr;
    reg_wdata_out = ~data;
  endtask : write_byte

  // one byte read; answer taken one cycle after the strobe edge
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic hit);
    @(negedge clk_in);
    reg_addr_out = addr;
    reg_read_out = 1'b1;
    @(negedge clk_in);
    reg_read_out = 1'b0;
    reg_addr_out = ~addr;
    data = reg_rdata_in;
    hit = reg_hit_in;
  endtask : read_byte

  // run bit driven to the requested level at a falling edge
  task automatic set_run(input logic level);
    @(negedge clk_in);
    run_out = level;
  endtask : set_run
endmodule : reg_host_model

// *** include/led_group_pkg.sv ***
// shared constants for the group / pattern register bank
// assumes a byte-wide register port fed by the serial front end
package led_group_pkg;

  // register offsets
  localparam logic [7:0] LOOP_TIME_OFS = 8'h84;
  localparam logic [7:0] LOOP_REPEAT_LOW_OFS = 8'h85;
  localparam logic [7:0] GROUP_LEVEL_HIGH_OFS = 8'h86;
  localparam logic [7:0] GROUP_LEVEL_LOW_OFS = 8'h87;
  localparam logic [7:0] GROUP_RED_OFS = 8'h88;
  localparam logic [7:0] GROUP_GREEN_OFS = 8'h89;
  localparam logic [7:0] GROUP_BLUE_OFS = 8'h8A;
  localparam logic [7:0] GROUP_CONFIG_OFS = 8'h8B;

  // reset values and unmapped answer
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // field positions
  localparam int SHARED_SCALE_DISABLE_BIT = 6;
  localparam int TRIO_ENABLE_MSB = 5;
  localparam int REPEAT_HIGH_MSB = 3;
  localparam int STOP_POINT_LSB = 6;
  localparam int LEVEL_HIGH_MSB = 3;

  // loop stop point code that ends at the off phase
  localparam logic [1:0] STOP_AT_OFF = 2'h0;

  // loop sequencer states, one-hot
  typedef enum logic [1:0] {
    LOOP_IDLE = 2'b01,
    LOOP_RUNNING = 2'b10
  } loop_state_t;

endpackage : led_group_pkg

// *** src/led_group_pattern_regs.sv ***
// group control and breathing pattern register bank
// assumes the serial front end hands over one byte access per strobe
`timescale 1ns/1ns
module led_group_pattern_regs
  import led_group_pkg::*;
#(
  parameter int CHANNEL_COUNT = 18
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register access from the serial front end
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  // bits held in neighbouring registers
  input wire logic pattern_engine_on_in,
  input wire logic run_in,
  // phase starts from the pattern timing engine
  input wire logic off_phase_start_in,
  input wire logic rise_phase_start_in,
  // per-channel scaling from the channel registers
  input wire logic [CHANNEL_COUNT*8-1:0] channel_colour_scaling_in,
  // group and pattern results
  output logic [11:0] group_duty_out,
  output logic [7:0] fade_max_out,
  output logic [7:0] fade_min_out,
  output logic [11:0] loop_repeat_count_out,
  output logic [1:0] loop_stop_point_out,
  output logic [CHANNEL_COUNT-1:0] channel_group_mode_out,
  output logic [CHANNEL_COUNT-1:0] channel_pattern_mode_out,
  output logic [CHANNEL_COUNT*8-1:0] channel_scale_out,
  // loop status
  output logic loop_running_out,
  output logic loop_over_out
);

  localparam int TRIO_COUNT = CHANNEL_COUNT / 3;

  initial begin
    if (CHANNEL_COUNT != 3 * (TRIO_ENABLE_MSB + 1)) begin
      $error("led_group_pattern_regs: CHANNEL_COUNT must match the trio field");
    end
  end

  // every register of the bank plus the read answer
  typedef struct packed {
    logic [7:0] loop_time;
    logic [7:0] loop_repeat_low;
    logic [7:0] group_level_high;
    logic [7:0] group_level_low;
    logic [7:0] group_red_scale;
    logic [7:0] group_green_scale;
    logic [7:0] group_blue_scale;
    logic [7:0] group_configuration;
    logic [7:0] rdata;
    logic hit;
  } bank_t;

  bank_t cur;
  bank_t next_cur;

  // address match, shared by read and write paths
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = addr >= LOOP_TIME_OFS && addr <= GROUP_CONFIG_OFS;
  endfunction : is_mapped

  // read multiplexer, unmapped offsets answer zero
  function automatic logic [7:0] read_mux(input bank_t b, input logic [7:0] addr);
    if (addr == LOOP_TIME_OFS) begin
      read_mux = b.loop_time;
    end else if (addr == LOOP_REPEAT_LOW_OFS) begin
      read_mux = b.loop_repeat_low;
    end else if (addr == GROUP_LEVEL_HIGH_OFS) begin
      read_mux = b.group_level_high;
    end else if (addr == GROUP_LEVEL_LOW_OFS) begin
      read_mux = b.group_level_low;
    end else if (addr == GROUP_RED_OFS) begin
      read_mux = b.group_red_scale;
    end else if (addr == GROUP_GREEN_OFS) begin
      read_mux = b.group_green_scale;
    end else if (addr == GROUP_BLUE_OFS) begin
      read_mux = b.group_blue_scale;
    end else if (addr == GROUP_CONFIG_OFS) begin
      read_mux = b.group_configuration;
    end else begin
      read_mux = UNMAPPED_READ;
    end
  endfunction : read_mux

  // colour of a channel from its index: 0 red, 1 green, 2 blue
  function automatic logic [7:0] shared_scale(input bank_t b, input int idx);
    case (idx % 3)
      0: shared_scale = b.group_red_scale;
      1: shared_scale = b.group_green_scale;
      default: shared_scale = b.group_blue_scale;
    endcase
  endfunction : shared_scale

  // trio bits spread to their three channels, used by the checks
  function automatic logic [CHANNEL_COUNT-1:0] trio_spread(input logic [7:0] cfg);
    trio_spread = '0;
    for (int t = 0; t < TRIO_COUNT; t++) begin
      trio_spread[3*t +: 3] = {3{cfg[t]}};
    end
  endfunction : trio_spread

  // register writes and registered read answer
  always_comb begin
    next_cur = cur;
    next_cur.hit = 1'b0;
    if (reg_read_in) begin
      next_cur.rdata = read_mux(cur, reg_addr_in);
      next_cur.hit = is_mapped(reg_addr_in);
    end
    if (reg_write_in) begin
      next_cur.hit = is_mapped(reg_addr_in);
      if (reg_addr_in == LOOP_TIME_OFS) begin
        next_cur.loop_time = reg_wdata_in;
      end else if (reg_addr_in == LOOP_REPEAT_LOW_OFS) begin
        next_cur.loop_repeat_low = reg_wdata_in;
      end else if (reg_addr_in == GROUP_LEVEL_HIGH_OFS) begin
        next_cur.group_level_high = reg_wdata_in;
      end else if (reg_addr_in == GROUP_LEVEL_LOW_OFS) begin
        next_cur.group_level_low = reg_wdata_in;
      end else if (reg_addr_in == GROUP_RED_OFS) begin
        next_cur.group_red_scale = reg_wdata_in;
      end else if (reg_addr_in == GROUP_GREEN_OFS) begin
        next_cur.group_green_scale = reg_wdata_in;
      end else if (reg_addr_in == GROUP_BLUE_OFS) begin
        next_cur.group_blue_scale = reg_wdata_in;
      end else if (reg_addr_in == GROUP_CONFIG_OFS) begin
        // bit 7 is reserved but kept read-write
        next_cur.group_configuration = reg_wdata_in;
      end
    end
  end

  // one register for the whole bank; every field resets to zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cur <= '{loop_time: REG_RESET, loop_repeat_low: REG_RESET,
               group_level_high: REG_RESET, group_level_low: REG_RESET,
               group_red_scale: REG_RESET, group_green_scale: REG_RESET,
               group_blue_scale: REG_RESET, group_configuration: REG_RESET,
               rdata: UNMAPPED_READ, hit: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata_out = cur.rdata;
  assign reg_hit_out = cur.hit;

  // join nibble and byte into the count
  assign loop_repeat_count_out = {cur.loop_time[REPEAT_HIGH_MSB:0], cur.loop_repeat_low};
  assign loop_stop_point_out = cur.loop_time[STOP_POINT_LSB+1:STOP_POINT_LSB];

  // group duty from both level registers outside pattern mode, zero in pattern mode
  // high byte feeds the top nibble only
  assign group_duty_out = pattern_engine_on_in ? 12'h000 :
    {cur.group_level_high[LEVEL_HIGH_MSB:0], cur.group_level_low};

  // fade ceiling and floor in pattern mode
  // held at zero outside pattern mode so the engine never sees a stale limit
  assign fade_max_out = pattern_engine_on_in ? cur.group_level_high : 8'h00;
  assign fade_min_out = pattern_engine_on_in ? cur.group_level_low : 8'h00;

  // per-channel mode and scaling selection
  for (genvar ch = 0; ch < CHANNEL_COUNT; ch++) begin : g_channel
    logic trio_on;
    assign trio_on = cur.group_configuration[ch / 3];
    assign channel_group_mode_out[ch] = trio_on && !pattern_engine_on_in;
    assign channel_pattern_mode_out[ch] = trio_on && pattern_engine_on_in;
    // own scaling when shared is disabled
    assign channel_scale_out[ch*8 +: 8] =
      (trio_on && !cur.group_configuration[SHARED_SCALE_DISABLE_BIT]) ?
      shared_scale(cur, ch) : channel_colour_scaling_in[ch*8 +: 8];
  end

  // loop run control and repeat counting
  loop_sequencer #(
    .REPEAT_WIDTH(12)
  ) u_loop (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(run_in),
    .repeat_count_in(loop_repeat_count_out),
    .stop_point_in(loop_stop_point_out),
    .off_phase_start_in(off_phase_start_in),
    .rise_phase_start_in(rise_phase_start_in),
    .loop_running_out(loop_running_out),
    .loop_over_out(loop_over_out)
  );

  // checks on register storage and routing
  // low byte stored
  chk_repeat_low_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_write_in && reg_addr_in == LOOP_REPEAT_LOW_OFS |=> loop_repeat_count_out[7:0] == $past(reg_wdata_in))
    else $error("repeat low byte not stored");

  chk_repeat_high_join: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_write_in && reg_addr_in == LOOP_TIME_OFS |=> loop_repeat_count_out[11:8] == $past(reg_wdata_in[3:0]))
    else $error("repeat high nibble not stored");

  chk_stop_point_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_write_in && reg_addr_in == LOOP_TIME_OFS |=> loop_stop_point_out == $past(reg_wdata_in[7:6]))
    else $error("stop point not stored");

  chk_fade_limit_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pattern_engine_on_in |-> fade_max_out == cur.group_level_high && fade_min_out == cur.group_level_low
    && group_duty_out == 12'h000)
    else $error("fade limits misrouted");

  chk_fade_min_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pattern_engine_on_in |-> fade_min_out == cur.group_level_low)
    else $error("fade floor misrouted");

  chk_group_duty_join: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_write_in && reg_addr_in == GROUP_LEVEL_LOW_OFS && !pattern_engine_on_in
    ##1 !pattern_engine_on_in |-> group_duty_out[7:0] == $past(reg_wdata_in))
    else $error("group duty low byte wrong");

  chk_group_duty_high: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pattern_engine_on_in |-> group_duty_out[11:8] == cur.group_level_high[3:0])
    else $error("group duty high nibble wrong");

  chk_group_duty_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pattern_engine_on_in |-> group_duty_out[7:0] == cur.group_level_low
    && fade_max_out == 8'h00 && fade_min_out == 8'h00)
    else $error("group duty low byte misrouted");

  chk_red_shared_scale: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !cur.group_configuration[6] |->
    (!cur.group_configuration[0] || channel_scale_out[7:0] == cur.group_red_scale)
    && (!cur.group_configuration[1] || channel_scale_out[31:24] == cur.group_red_scale))
    else $error("red channels lost shared scaling");

  chk_green_shared_scale: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cur.group_configuration[1] && !cur.group_configuration[6] |-> channel_scale_out[39:32] == cur.group_green_scale)
    else $error("green channel lost shared scaling");

  chk_blue_shared_scale: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cur.group_configuration[5] && !cur.group_configuration[6] |-> channel_scale_out[143:136] == cur.group_blue_scale)
    else $error("blue channel lost shared scaling");

  chk_trio_shared_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cur.group_configuration[2] && !cur.group_configuration[6] |->
    channel_scale_out[55:48] == cur.group_red_scale && channel_scale_out[63:56] == cur.group_green_scale
    && channel_scale_out[71:64] == cur.group_blue_scale)
    else $error("trio lost shared scaling");

  chk_own_scale_used: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cur.group_configuration[6] |-> channel_scale_out == channel_colour_scaling_in)
    else $error("own scaling not used");

  chk_trio_mode_split: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pattern_engine_on_in |-> channel_pattern_mode_out == trio_spread(cur.group_configuration) && channel_group_mode_out == '0)
    else $error("trio mode bits inconsistent");

  chk_trio_group_one: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pattern_engine_on_in |-> channel_group_mode_out[5:3] == {3{cur.group_configuration[1]}}
    && channel_pattern_mode_out == '0)
    else $error("trio one not in group mode");

  chk_trio_group_all: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pattern_engine_on_in |-> channel_group_mode_out == trio_spread(cur.group_configuration))
    else $error("group trios do not follow their bits");

  // unmapped offsets answer zero and miss
  chk_unmapped_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_read_in && !is_mapped(reg_addr_in) |=> reg_rdata_out == UNMAPPED_READ && !reg_hit_out)
    else $error("unmapped read answered");

  chk_config_readback: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_read_in && reg_addr_in == GROUP_CONFIG_OFS |=> reg_rdata_out == $past(cur.group_configuration) && reg_hit_out)
    else $error("configuration read back wrong");

  chk_loop_time_readback: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_read_in && reg_addr_in == LOOP_TIME_OFS |=> reg_rdata_out == $past(cur.loop_time) && reg_hit_out)
    else $error("loop time read back wrong");

  // mapped write answers hit
  chk_write_hit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_write_in && is_mapped(reg_addr_in) |=> reg_hit_out)
    else $error("mapped write not acknowledged");

  // main scenarios worth seeing
  cov_group_mode: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    !pattern_engine_on_in && channel_group_mode_out != '0);

  cov_pattern_mode: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    pattern_engine_on_in && loop_running_out);

  cov_own_scale: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    cur.group_configuration[6] && channel_group_mode_out != '0);

  cov_config_read: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    reg_read_in && reg_addr_in == GROUP_CONFIG_OFS);

endmodule : led_group_pattern_regs

// *** src/loop_sequencer.sv ***
// breathing loop repeat counter and run control
// assumes phase start pulses come from the pattern timing engine
`timescale 1ns/1ns
module loop_sequencer
  import led_group_pkg::*;
#(
  parameter int REPEAT_WIDTH = 12
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic run_in,
  input wire logic [REPEAT_WIDTH-1:0] repeat_count_in,
  input wire logic [1:0] stop_point_in,
  // phase starts from the timing engine
  input wire logic off_phase_start_in,
  input wire logic rise_phase_start_in,
  // status
  output logic loop_running_out,
  output logic loop_over_out
);

  initial begin
    if (REPEAT_WIDTH < 1 || REPEAT_WIDTH > 16) $error("loop_sequencer: bad REPEAT_WIDTH");
  end

  typedef struct packed {
    loop_state_t state;
    logic run_prev;
    logic over;
    logic [REPEAT_WIDTH-1:0] count;
  } seq_t;

  seq_t cur;
  seq_t next_cur;
  logic start;
  logic boundary;
  logic [REPEAT_WIDTH-1:0] next_count;

  assign start = run_in && !cur.run_prev;
  assign boundary = (stop_point_in == STOP_AT_OFF) ? off_phase_start_in : rise_phase_start_in;
  assign next_count = cur.count + 1'b1;

  // sequencer next state
  always_comb begin
    next_cur = cur;
    next_cur.run_prev = run_in;
    case (cur.state)
      LOOP_IDLE: begin
        if (start) begin
          next_cur.state = LOOP_RUNNING;
          next_cur.count = '0;
          next_cur.over = 1'b0;
        end
      end
      LOOP_RUNNING: begin
        if (!run_in) begin
          next_cur.state = LOOP_IDLE;
        end else if (boundary) begin
          next_cur.count = next_count;
          if (repeat_count_in != '0 && next_count == repeat_count_in) begin
            next_cur.state = LOOP_IDLE;
            next_cur.over = 1'b1;
          end
        end
      end
      default: begin
        next_cur.state = LOOP_IDLE;
      end
    endcase
  end

  // state register; run_prev resets low so a high run at release starts
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cur <= '{state: LOOP_IDLE, run_prev: 1'b0, over: 1'b0, count: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign loop_running_out = cur.state == LOOP_RUNNING;
  assign loop_over_out = cur.over;

  chk_loop_start_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cur.state == LOOP_IDLE && run_in && !cur.run_prev |=> loop_running_out && !loop_over_out)
    else $error("loop did not start on run edge");
  chk_loop_forever_run: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    loop_running_out && run_in && repeat_count_in == '0 |=> loop_running_out)
    else $error("zero repeat count stopped the loop");
  chk_loop_end_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    loop_running_out && run_in && boundary && repeat_count_in != '0
    && next_count == repeat_count_in |=> !loop_running_out && loop_over_out)
    else $error("loop did not end at its repeat count");
  chk_loop_stop_phase: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    loop_running_out && stop_point_in == STOP_AT_OFF && !off_phase_start_in |=> $stable(cur.count))
    else $error("loop counted outside the off phase start");
  cov_loop_finished: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(loop_over_out));

endmodule : loop_sequencer
